// *** rtl/ebc_top.sv ***
// Break and run control of the emulator, with an AXI4-Lite register slave.
// Assumes core cycle strobes on REF_CLK; pins for external events are async.
`timescale 1ns/10ps
`default_nettype none

module ebc_top
  import ebc_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  // AXI4-Lite slave
  input  wire logic [7:0]        S_AWADDR,
  input  wire logic              S_AWVALID,
  output var  logic              S_AWREADY,
  input  wire logic [31:0]       S_WDATA,
  input  wire logic [3:0]        S_WSTRB,
  input  wire logic              S_WVALID,
  output var  logic              S_WREADY,
  output var  logic [1:0]        S_BRESP,
  output var  logic              S_BVALID,
  input  wire logic              S_BREADY,
  input  wire logic [7:0]        S_ARADDR,
  input  wire logic              S_ARVALID,
  output var  logic              S_ARREADY,
  output var  logic [31:0]       S_RDATA,
  output var  logic [1:0]        S_RRESP,
  output var  logic              S_RVALID,
  input  wire logic              S_RREADY,
  // Emulated core
  input  wire ebc_cycle_s        CORE_CYCLE,
  output var  logic              CORE_RUN,
  output var  logic              CORE_FORCE_OP,
  output var  logic [OP_W-1:0]   CORE_OPCODE,
  // Trace unit and trigger pins
  output var  logic              TRACE_STORE,
  output var  logic              TRIG_OUT,
  // Async halt conditions and interrupt output
  input  wire logic              EXT_BREAK,
  input  wire logic              STACK_OVF,
  input  wire logic              WDT_TIMEOUT,
  output var  logic              IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ebc_state_e        state_reg;
  logic [2:0]        ext_sync;
  logic [2:0]        ext_prev_reg;
  logic [SRC_W-1:0]  src_en_reg;
  logic [SRC_W-1:0]  cause_reg;
  logic              brk_en_reg;
  logic [ADDR_W-1:0] run_addr_reg;
  logic              run_to_reg;
  logic [ADDR_W-1:0] pass_addr_reg;
  logic [15:0]       pass_cnt_reg;
  logic [OP_W-1:0]   opcode_reg;
  logic [ADDR_W-1:0] mark_addr_reg;
  logic              mark_wr;
  logic [2:0]        host_mark;
  logic [TRACE_W-1:0] trace_cnt_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_en_reg;
  logic [IRQ_W-1:0]  irq_set;
  logic              cyc_d_reg;
  ebc_cycle_s        cyc_reg;
  ebc_mark_s         mark;
  logic [SRC_W-1:0]  hit;
  logic              halt_req;
  logic              user_halt;
  logic              ctl_run;
  logic              ctl_step;
  logic              ctl_exec;
  logic              ctl_run_to;
  logic              pass_zero_hit;
  logic              wr_go;
  logic              rd_go;

  // ----------------------------------------------------------------
  // Input synchronisers and mark store
  // ----------------------------------------------------------------
  ebc_sync #(.W(3)) u_sync (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .d     ({WDT_TIMEOUT, STACK_OVF, EXT_BREAK}),
    .q     (ext_sync)
  );

  ebc_marks u_marks (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .wr_en     (mark_wr),
    .wr_addr   (mark_addr_reg),
    .wr_data   (S_WDATA[2:0]),
    .rd_addr   (CORE_CYCLE.addr),
    .rd_mark   (mark),
    .host_mark (host_mark)
  );

  // Hold the cycle while its marks are looked up
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cyc_reg      <= '0;
      cyc_d_reg    <= 1'b0;
      ext_prev_reg <= '0;
    end else begin
      cyc_reg      <= CORE_CYCLE;
      cyc_d_reg    <= CORE_CYCLE.valid;
      ext_prev_reg <= ext_sync;
    end
  end

  // ----------------------------------------------------------------
  // Halt sources
  // ----------------------------------------------------------------
  // Only a completed genuine fetch counts, so the halt follows it
  assign pass_zero_hit = is_fetch(cyc_reg) && (cyc_reg.addr == pass_addr_reg)
                         && (pass_cnt_reg == 16'h0001);
  always_comb begin
    hit             = '0;
    hit[SRC_ADDR]   = is_fetch(cyc_reg) && mark.brk;
    hit[SRC_TFULL]  = TRACE_STORE && (trace_cnt_reg == TRACE_FULL);
    hit[SRC_PASS]   = pass_zero_hit;
    hit[SRC_EXT]    = ext_sync[0] && !ext_prev_reg[0];
    hit[SRC_STACK]  = ext_sync[1] && !ext_prev_reg[1];
    hit[SRC_WDT]    = ext_sync[2] && !ext_prev_reg[2];
    hit[SRC_USER]   = user_halt;
    hit[SRC_RUNTO]  = run_to_reg && is_fetch(cyc_reg) && (cyc_reg.addr == run_addr_reg);
  end

  // With break logic on, any enabled source halts at once, pass count or not; user halt and run-to always halt
  assign halt_req = (brk_en_reg && |(hit & src_en_reg & ~(SRC_W'(1) << SRC_USER)))
                    || hit[SRC_USER] || hit[SRC_RUNTO];

  // ----------------------------------------------------------------
  // Run state machine
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_HALTED;
    end else begin
      case (state_reg)
        ST_HALTED: begin
          if (ctl_run || ctl_run_to) begin
            state_reg <= ST_RUN;
          end else if (ctl_step) begin
            state_reg <= ST_STEP;
          end else if (ctl_exec) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_RUN: begin
          if (state_reg == ST_RUN && halt_req) begin
            state_reg <= ST_HALTED;
          end
        end
        // One genuine fetch completes, then back to halted
        ST_STEP, ST_EXEC: begin
          if (is_fetch(CORE_CYCLE)) begin
            state_reg <= ST_HALTED;
          end
        end
        default: state_reg <= ST_HALTED;
      endcase
    end
  end

  // Core control pins; extra cycles of the step drain before stop
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CORE_RUN      <= 1'b0;
      CORE_FORCE_OP <= 1'b0;
      CORE_OPCODE   <= '0;
    end else begin
      CORE_RUN      <= (state_reg == ST_RUN && !halt_req)
                       || ((state_reg == ST_STEP || state_reg == ST_EXEC)
                           && !is_fetch(CORE_CYCLE))
                       || (state_reg == ST_HALTED && (ctl_run || ctl_run_to || ctl_step
                                                      || ctl_exec));
      CORE_FORCE_OP <= (state_reg == ST_HALTED && ctl_exec)
                       || (state_reg == ST_EXEC && !is_fetch(CORE_CYCLE));
      CORE_OPCODE   <= opcode_reg;
    end
  end

  // Trace store follows every completed cycle, marks or not; trigger follows its mark
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TRACE_STORE <= 1'b0;
      TRIG_OUT    <= 1'b0;
    end else begin
      TRACE_STORE <= CORE_CYCLE.valid;
      TRIG_OUT    <= cyc_d_reg && mark.trig && cyc_reg.valid;
    end
  end

  // Count stored trace cycles; restart on each run
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trace_cnt_reg <= '0;
    end else if (state_reg == ST_HALTED && (ctl_run || ctl_run_to)) begin
      trace_cnt_reg <= '0;
    end else if (TRACE_STORE && trace_cnt_reg != TRACE_FULL) begin
      trace_cnt_reg <= trace_cnt_reg + 1'b1;
    end
  end

  // Pass counter decrements each time its address executes, stopping at zero
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pass_cnt_reg <= '0;
    end else if (wr_go && S_AWADDR == OFS_PASS_CNT) begin
      pass_cnt_reg <= S_WDATA[15:0];
    end else if (is_fetch(cyc_reg) && cyc_reg.addr == pass_addr_reg && pass_cnt_reg != '0) begin
      pass_cnt_reg <= pass_cnt_reg - 1'b1;
    end
  end

  // Cause latches the sources present when the halt is taken
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cause_reg <= '0;
      run_to_reg <= 1'b0;
    end else if (state_reg == ST_RUN && halt_req) begin
      cause_reg  <= hit;
      run_to_reg <= 1'b0;
    end else if (state_reg == ST_HALTED && ctl_run_to) begin
      cause_reg  <= '0;
      run_to_reg <= 1'b1;
    end else if (state_reg == ST_HALTED && ctl_run) begin
      cause_reg  <= '0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave: both channels taken together, answer one cycle later
  // ----------------------------------------------------------------
  assign wr_go = S_AWVALID && S_WVALID && !S_BVALID;
  assign rd_go = S_ARVALID && !S_RVALID;
  assign mark_wr    = wr_go && S_AWADDR == OFS_MARK_DATA;
  assign ctl_run    = wr_go && S_AWADDR == OFS_CTRL && S_WDATA[CTRL_RUN];
  assign user_halt  = wr_go && S_AWADDR == OFS_CTRL && S_WDATA[CTRL_HALT];
  assign ctl_step   = wr_go && S_AWADDR == OFS_CTRL && S_WDATA[CTRL_STEP];
  assign ctl_exec   = wr_go && S_AWADDR == OFS_CTRL && S_WDATA[CTRL_EXEC_OP];
  assign ctl_run_to = wr_go && S_AWADDR == OFS_CTRL && S_WDATA[CTRL_RUN_TO];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AWREADY <= 1'b0;
      S_WREADY  <= 1'b0;
      S_BVALID  <= 1'b0;
      S_BRESP   <= RESP_OKAY;
    end else begin
      S_AWREADY <= wr_go;
      S_WREADY  <= wr_go;
      if (wr_go) begin
        S_BVALID <= 1'b1;
        S_BRESP  <= (S_AWADDR > OFS_IRQ_EN || S_AWADDR[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
      end else if (S_BREADY) begin
        S_BVALID <= 1'b0;
      end
    end
  end

  // Writable registers; the strobe is taken as all lanes
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brk_en_reg    <= 1'b0;
      src_en_reg    <= '0;
      run_addr_reg  <= '0;
      pass_addr_reg <= '0;
      opcode_reg    <= '0;
      mark_addr_reg <= '0;
      irq_en_reg    <= '0;
    end else if (wr_go) begin
      case (S_AWADDR)
        OFS_CTRL:      brk_en_reg    <= S_WDATA[CTRL_BRK_EN];
        OFS_SRC_EN:    src_en_reg    <= S_WDATA[SRC_W-1:0];
        OFS_RUN_ADDR:  run_addr_reg  <= S_WDATA[ADDR_W-1:0];
        OFS_PASS_ADDR: pass_addr_reg <= S_WDATA[ADDR_W-1:0];
        OFS_OPCODE:    opcode_reg    <= S_WDATA[OP_W-1:0];
        OFS_MARK_ADDR: mark_addr_reg <= S_WDATA[ADDR_W-1:0];
        OFS_IRQ_EN:    irq_en_reg    <= S_WDATA[IRQ_W-1:0];
        default:       ;
      endcase
    end
  end

  // Sticky events; a set in the clear cycle wins
  assign irq_set[IRQ_HALTED]  = state_reg == ST_RUN && halt_req;
  assign irq_set[IRQ_STEPPED] = (state_reg == ST_STEP || state_reg == ST_EXEC)
                                && is_fetch(CORE_CYCLE);
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat_reg <= '0;
      IRQ          <= 1'b0;
    end else begin
      if (wr_go && S_AWADDR == OFS_IRQ_CLR) begin
        irq_stat_reg <= (irq_stat_reg & ~S_WDATA[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      IRQ <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Read channel
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_ARREADY <= 1'b0;
      S_RVALID  <= 1'b0;
      S_RDATA   <= '0;
      S_RRESP   <= RESP_OKAY;
    end else begin
      S_ARREADY <= rd_go;
      if (rd_go) begin
        S_RVALID <= 1'b1;
        S_RRESP  <= RESP_OKAY;
        case (S_ARADDR)
          OFS_CTRL:      S_RDATA <= 32'(brk_en_reg) << CTRL_BRK_EN;
          OFS_STATUS:    S_RDATA <= 32'(state_reg == ST_HALTED);
          OFS_CAUSE:     S_RDATA <= 32'(cause_reg);
          OFS_SRC_EN:    S_RDATA <= 32'(src_en_reg);
          OFS_RUN_ADDR:  S_RDATA <= 32'(run_addr_reg);
          OFS_PASS_ADDR: S_RDATA <= 32'(pass_addr_reg);
          OFS_PASS_CNT:  S_RDATA <= 32'(pass_cnt_reg);
          OFS_OPCODE:    S_RDATA <= 32'(opcode_reg);
          OFS_MARK_ADDR: S_RDATA <= 32'(mark_addr_reg);
          OFS_MARK_DATA: S_RDATA <= 32'(host_mark);
          OFS_TRACE_CNT: S_RDATA <= 32'(trace_cnt_reg);
          OFS_IRQ_STAT:  S_RDATA <= 32'(irq_stat_reg);
          OFS_IRQ_EN:    S_RDATA <= 32'(irq_en_reg);
          default: begin
            S_RDATA <= '0;
            S_RRESP <= RESP_SLVERR;
          end
        endcase
      end else if (S_RREADY) begin
        S_RVALID <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** rtl/ebc_pkg.sv ***
// Package for the emulator break control block: offsets, fields, types.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
package ebc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam int          OP_W          = 16;
  localparam int          MARK_DEPTH    = 1 << ADDR_W;
  localparam int          TRACE_W       = 14;
  localparam logic [13:0] TRACE_FULL    = 14'h1FFF;  // 8K stored cycles, less one
  localparam int          SRC_W         = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_CAUSE     = 8'h08;
  localparam logic [7:0] OFS_SRC_EN    = 8'h0C;
  localparam logic [7:0] OFS_RUN_ADDR  = 8'h10;
  localparam logic [7:0] OFS_PASS_ADDR = 8'h14;
  localparam logic [7:0] OFS_PASS_CNT  = 8'h18;
  localparam logic [7:0] OFS_OPCODE    = 8'h1C;
  localparam logic [7:0] OFS_MARK_ADDR = 8'h20;
  localparam logic [7:0] OFS_MARK_DATA = 8'h24;
  localparam logic [7:0] OFS_TRACE_CNT = 8'h28;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h2C;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h30;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h34;

  // ----------------------------------------------------------------
  // Control register bits (write one to act, self clearing, except the stored CTRL_BRK_EN)
  // ----------------------------------------------------------------
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_HALT    = 1;
  localparam int CTRL_STEP    = 2;
  localparam int CTRL_EXEC_OP = 3;
  localparam int CTRL_RUN_TO  = 4;
  localparam int CTRL_BRK_EN  = 5;  // Stored level: break logic enabled

  // Mark bits in the mark memory
  localparam int MARK_BRK  = 0;
  localparam int MARK_TRC  = 1;
  localparam int MARK_TRIG = 2;

  // Halt source bit positions (cause and enable layout)
  localparam int SRC_ADDR   = 0;
  localparam int SRC_TFULL  = 1;
  localparam int SRC_PASS   = 2;
  localparam int SRC_EXT    = 3;
  localparam int SRC_STACK  = 4;
  localparam int SRC_WDT    = 5;
  localparam int SRC_USER   = 6;
  localparam int SRC_RUNTO  = 7;

  // Interrupt event bits
  localparam int IRQ_HALTED = 0;
  localparam int IRQ_STEPPED = 1;
  localparam int IRQ_W = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum {ST_HALTED, ST_RUN, ST_STEP, ST_EXEC} ebc_state_e;

  // Per-cycle information from the emulated core
  typedef struct packed {
    logic              valid;   // One core cycle completed
    logic              first;   // Genuine instruction fetch, not an extra cycle
    logic [ADDR_W-1:0] addr;
    logic [OP_W-1:0]   data;
  } ebc_cycle_s;

  // Marks that travel from the mark store to the control logic
  typedef struct packed {
    logic brk;
    logic trc;
    logic trig;
  } ebc_mark_s;

  function automatic logic is_fetch(input ebc_cycle_s c);
    return c.valid && c.first;
  endfunction

endpackage

// *** rtl/ebc_sync.sv ***
// Two flip-flop synchroniser for asynchronous level inputs.
// Assumes the inputs change slowly compared to the clock.
`timescale 1ns/10ps
`default_nettype none
module ebc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// *** rtl/ebc_marks.sv ***
// Mark store: one break, trace and trigger bit for every program address.
// Assumes one lookup per clock; writes come from the register slave.
`timescale 1ns/10ps
`default_nettype none
module ebc_marks
  import ebc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [2:0]        wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output var  ebc_mark_s         rd_mark,
  output var  logic [2:0]        host_mark
);

  // Separate bits per kind; each write replaces all three bits of an address
  logic [2:0] mem [MARK_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered lookup; the caller waits one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_mark   <= '0;
      host_mark <= '0;
    end else begin
      rd_mark   <= '{brk: mem[rd_addr][MARK_BRK], trc: mem[rd_addr][MARK_TRC],
                     trig: mem[rd_addr][MARK_TRIG]};
      host_mark <= mem[wr_addr];
    end
  end

endmodule
`default_nettype wire

// *** sim/ebc_top_props.sv ***
// Port-level assertions for the break control top.
// Assumes the single REF_CLK domain; bound to every ebc_top below.
`timescale 1ns/10ps
`default_nettype none
module ebc_top_props (
  input wire logic               REF_CLK,
  input wire logic               RST_N,
  input wire logic               S_AWVALID,
  input wire logic               S_WVALID,
  input wire logic               S_AWREADY,
  input wire logic               S_WREADY,
  input wire logic               S_BVALID,
  input wire logic               S_BREADY,
  input wire logic [1:0]         S_BRESP,
  input wire logic               S_ARVALID,
  input wire logic               S_ARREADY,
  input wire logic               S_RVALID,
  input wire logic               S_RREADY,
  input wire logic [31:0]        S_RDATA,
  input wire logic [1:0]         S_RRESP,
  input wire ebc_pkg::ebc_cycle_s CORE_CYCLE,
  input wire logic               CORE_FORCE_OP,
  input wire logic [15:0]        CORE_OPCODE,
  input wire logic               TRACE_STORE,
  input wire logic               TRIG_OUT
);
  import ebc_pkg::*;
  // ----
  // Handshake and core-side relations
  // ----
  default clocking dcb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // A write is taken, then answered the next cycle
  sequence wr_req; S_AWVALID && S_WVALID && !S_BVALID && !S_AWREADY; endsequence
  sequence wr_ack; S_AWREADY && S_WREADY && S_BVALID; endsequence
  wr_answer_a: assert property (wr_req |=> wr_ack)
    else $error("write not answered");
  ready_pulse_a: assert property (S_AWREADY |=> !S_AWREADY && !S_WREADY)
    else $error("write ready stuck");
  bresp_hold_a: assert property (S_BVALID && !S_BREADY |=> S_BVALID && $stable(S_BRESP))
    else $error("write response dropped");
  rd_answer_a: assert property (S_ARVALID && !S_RVALID && !S_ARREADY |=> S_ARREADY && S_RVALID)
    else $error("read not answered");
  rdata_hold_a: assert property (S_RVALID && !S_RREADY |=> S_RVALID && $stable(S_RDATA))
    else $error("read data dropped");
  slverr_zero_a: assert property (S_RVALID && S_RRESP == RESP_SLVERR |-> S_RDATA == 32'h0)
    else $error("error read with data");
  trace_cause_a: assert property (TRACE_STORE |-> $past(CORE_CYCLE.valid))
    else $error("trace store without cycle");
  trig_cause_a: assert property (TRIG_OUT |-> $past(CORE_CYCLE.valid, 2))
    else $error("trigger without cycle");
  op_stable_a: assert property (CORE_FORCE_OP [*2] |-> $stable(CORE_OPCODE))
    else $error("opcode changed while forced");
  op_done_a: assert property ($rose(CORE_FORCE_OP) |-> ##[1:64] !CORE_FORCE_OP)
    else $error("forced opcode never ends");
endmodule
bind ebc_top ebc_top_props u_props (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .S_AWVALID(S_AWVALID), .S_WVALID(S_WVALID),
  .S_AWREADY(S_AWREADY), .S_WREADY(S_WREADY), .S_BVALID(S_BVALID), .S_BREADY(S_BREADY),
  .S_BRESP(S_BRESP), .S_ARVALID(S_ARVALID), .S_ARREADY(S_ARREADY), .S_RVALID(S_RVALID),
  .S_RREADY(S_RREADY), .S_RDATA(S_RDATA), .S_RRESP(S_RRESP), .CORE_CYCLE(CORE_CYCLE),
  .CORE_FORCE_OP(CORE_FORCE_OP), .CORE_OPCODE(CORE_OPCODE), .TRACE_STORE(TRACE_STORE),
  .TRIG_OUT(TRIG_OUT));
`default_nettype wire

// *** sim/ebc_core_model.sv ***
// Slow model of the emulated core: loops over 128 addresses.
// Assumes run and force strobes on the same clock as the block.
`timescale 1ns/10ps
`default_nettype none
module ebc_core_model #(
  parameter int GAP = 4
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                run,
  input  wire logic                force_op,
  input  wire logic [15:0]         opcode,
  output var  ebc_pkg::ebc_cycle_s cyc,
  output var  logic [15:0]         fetches,
  output var  logic [15:0]         forced,
  output var  logic [15:0]         last_addr,
  output var  logic [15:0]         last_op
);
  import ebc_pkg::*;
  logic [15:0] pc;
  logic [15:0] xaddr;
  logic [2:0]  slot;
  logic        extra_due;
  wire  logic  go;
  assign go = (run || force_op) && slot == 3'(GAP - 1);
  // One cycle per GAP clocks; idle bus flips so stale values never match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {slot, pc, xaddr, extra_due, cyc} <= '0;
      {fetches, forced, last_addr, last_op} <= '0;
    end else begin
      slot <= ((run || force_op) && !go) ? slot + 3'h1 : 3'h0;
      cyc.valid <= go;
      cyc.first <= go && (force_op || !extra_due);
      cyc.addr <= ~cyc.addr;
      cyc.data <= ~cyc.data;
      if (go && force_op) begin
        cyc.addr <= pc;
        cyc.data <= opcode;
        forced <= forced + 16'h1;
        last_op <= opcode;
      end else if (go && extra_due) begin  // extra cycle far from next fetch
        cyc.addr <= xaddr;
        extra_due <= 1'b0;
      end else if (go) begin
        cyc.addr <= pc;
        cyc.data <= pc ^ 16'h3C3C;
        fetches <= fetches + 16'h1;
        last_addr <= pc;
        pc <= {9'h0, pc[6:0] + 7'h1};
        extra_due <= pc[2:0] == 3'h7;
        xaddr <= pc | 16'h0100;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench: AXI4-Lite host tasks against a slow core model.
// Assumes the checker is bound to ebc_top by its own file.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ebc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic        awr, wr_rdy, bvalid, arr, rvalid, irq, run, fop, tstore, trig;
  logic [1:0]  bresp, rresp, resp_v;
  logic [31:0] rdata, rd_v;
  logic [15:0] opcode, fetches, forced, last_addr, last_op, f0;
  logic [2:0]  ext_v = 3'b000;  // External break, stack overflow, watchdog
  ebc_cycle_s  cyc;
  int          mismatches = 0, n_compared = 0, cycles = 0, trig_seen = 0;

  always #2.5 clk = ~clk;

  ebc_top DUT (
    .REF_CLK(clk), .RST_N(rst_n), .S_AWADDR(awaddr), .S_AWVALID(awv), .S_AWREADY(awr),
    .S_WDATA(wdata), .S_WSTRB(4'hF), .S_WVALID(wv), .S_WREADY(wr_rdy), .S_BRESP(bresp),
    .S_BVALID(bvalid), .S_BREADY(bready), .S_ARADDR(araddr), .S_ARVALID(arv),
    .S_ARREADY(arr), .S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid),
    .S_RREADY(rready), .CORE_CYCLE(cyc), .CORE_RUN(run), .CORE_FORCE_OP(fop),
    .CORE_OPCODE(opcode), .TRACE_STORE(tstore), .TRIG_OUT(trig), .EXT_BREAK(ext_v[0]),
    .STACK_OVF(ext_v[1]), .WDT_TIMEOUT(ext_v[2]), .IRQ(irq));
  ebc_core_model u_core (
    .clk(clk), .rst_n(rst_n), .run(run), .force_op(fop), .opcode(opcode), .cyc(cyc),
    .fetches(fetches), .forced(forced), .last_addr(last_addr), .last_op(last_op));

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awv, wv} <= 2'b11;
    do @(posedge clk); while (awr !== 1'b1);
    {awv, wv} <= 2'b00;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp_v = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd_v = rdata;
    resp_v = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask
  task automatic mark(input logic [15:0] a, input logic [2:0] m);
    wr(OFS_MARK_ADDR, {16'h0, a});
    wr(OFS_MARK_DATA, {29'h0, m});
  endtask
  // Poll for the halted state, then check the recorded cause
  task automatic wait_halt(input logic [31:0] cause);
    do rd(OFS_STATUS); while (rd_v[0] !== 1'b1);
    rchk(OFS_CAUSE, cause);
  endtask

  // Hang guard and trigger pulse counter
  always @(posedge clk) begin
    cycles++;
    if (trig === 1'b1) trig_seen++;
    if (cycles == 60000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OFS_STATUS, 32'h1);
    rchk(OFS_IRQ_EN, 32'h0);
    rd(8'h3C);
    chk({30'h0, resp_v}, {30'h0, RESP_SLVERR});
    wr(8'h38, 32'h1);
    chk({30'h0, resp_v}, {30'h0, RESP_SLVERR});
    // Mark store powers up unknown: clear every address the core visits
    for (int a = 0; a < 384; a++) mark(16'(a), 3'b000);
    // Marks of each kind, well under sixteen per kind
    mark(16'h005A, 3'b001);
    mark(16'h0157, 3'b001);
    mark(16'h0021, 3'b100);
    mark(16'h0020, 3'b010);
    wr(OFS_MARK_ADDR, 32'h5A);
    rchk(OFS_MARK_DATA, 32'h1);
    wr(OFS_MARK_ADDR, 32'h21);
    rchk(OFS_MARK_DATA, 32'h4);
    wr(OFS_SRC_EN, 32'hFF);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_PASS_ADDR, 32'h10);
    wr(OFS_PASS_CNT, 32'h3);
    // Address break; the extra cycle at 0157 must not stop the core
    wr(OFS_CTRL, 32'h21);
    wait_halt(32'h1);
    chk({16'h0, last_addr}, 32'h5A);
    chk(32'(trig_seen), 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_CLR, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Address mark hit while the pass counter still counts
    wr(OFS_CTRL, 32'h21);
    wait_halt(32'h1);
    chk({16'h0, last_addr}, 32'h5A);
    mark(16'h005A, 3'b000);
    wr(OFS_PASS_CNT, 32'h2);
    wr(OFS_CTRL, 32'h21);
    wait_halt(32'h4);
    chk({16'h0, last_addr}, 32'h10);
    // Run-to with break logic off
    wr(OFS_RUN_ADDR, 32'h30);
    wr(OFS_CTRL, 32'h10);
    wait_halt(32'h80);
    chk({16'h0, last_addr}, 32'h30);
    // Free run until the trace store fills
    wr(OFS_CTRL, 32'h21);
    wait_halt(32'h2);
    rchk(OFS_TRACE_CNT, 32'h1FFF);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 32'h21);
      repeat (20) @(posedge clk);
      ext_v[i] <= 1'b1;
      wait_halt(32'h8 << i);
      ext_v[i] <= 1'b0;
    end
    // User halt with the interrupt masked
    wr(OFS_IRQ_CLR, 32'h3);
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_CTRL, 32'h01);
    wr(OFS_CTRL, 32'h02);
    wait_halt(32'h40);
    rchk(OFS_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // One step, then still halted
    wr(OFS_IRQ_CLR, 32'h3);
    f0 = fetches;
    wr(OFS_CTRL, 32'h04);
    do rd(OFS_IRQ_STAT); while (rd_v[1] !== 1'b1);
    chk({16'h0, fetches}, {16'h0, f0 + 16'h1});
    rchk(OFS_STATUS, 32'h1);
    // Host opcode runs exactly once without moving the program
    f0 = fetches;
    wr(OFS_OPCODE, 32'hA5C3);
    wr(OFS_CTRL, 32'h08);
    while (forced === 16'h0) @(posedge clk);
    repeat (40) @(posedge clk);
    chk({16'h0, forced}, 32'h1);
    chk({16'h0, last_op}, 32'hA5C3);
    chk({16'h0, fetches}, {16'h0, f0});
    end_sim();
  end
endmodule
`default_nettype wire
